/* core/ptlv_decoder.v */
// Proprietary template decoder with AHB-Lite register slave
//
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "ptlv_defs.vh"
module ptlv_decoder (
    input wire clk_i,
    input wire srst_i,
    input wire ce_i,
    input wire rx_valid_i,
    input wire [7:0] rx_byte_i,
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output reg [31:0] hrdata_o,
    output reg hreadyout_o,
    output reg hresp_o,
    output reg done_o,
    output reg error_o,
    output reg clk_stop_any_o,
    output reg stop_high_ok_o,
    output reg stop_low_ok_o,
    output reg [1:0] stop_pref_o,
    output reg [2:0] volt_class_o
);
    localparam [5:0] S_IDLE = 6'h01;
    localparam [5:0] S_TLEN = 6'h02;
    localparam [5:0] S_TAG = 6'h04;
    localparam [5:0] S_LEN = 6'h08;
    localparam [5:0] S_VAL = 6'h10;
    localparam [5:0] S_SKIP = 6'h20;

    reg [5:0] state;
    reg [7:0] tmpl_rem;
    reg [7:0] obj_rem;
    reg [7:0] cur_tag;
    reg [7:0] last_tag;
    reg [8:0] seen;
    reg [23:0] val_sr;
    reg first_val;
    reg [7:0] char_byte;
    reg char_valid;
    reg [1:0] file_kind;
    reg [11:0] status;
    reg [11:0] next_status;
    reg store_clr;
    reg power_wr;
    reg minclk_wr;
    reg [23:0] store_data;
    reg ph_write;
    reg [7:0] ph_addr;
    reg ph_valid;

    wire [2:0] power_count;
    wire [2:0] minclk_count;
    wire [23:0] power_rd;
    wire [7:0] minclk_rd;
    wire power_ovf;
    wire minclk_ovf;
    wire rx_take = ce_i & rx_valid_i;
    wire last_private = (last_tag & `PTLV_TAG_PRIVATE_MASK) == `PTLV_TAG_PRIVATE_MASK;
    wire is_defined = (rx_byte_i >= `PTLV_TAG_CHAR) && (rx_byte_i <= `PTLV_TAG_ENV);
    wire [3:0] tag_idx = rx_byte_i[3:0];
    wire [7:0] rem_after = tmpl_rem - 8'h01;
    wire [23:0] val_next = {val_sr[15:0], rx_byte_i};
    wire addr_ok = hsel_i & htrans_i[1] & hready_i;

    ////////////////////////////////////////////////////////////////////////
    // Ordered stores for repeated power and clock objects
    tlv_repeat_store #(.WIDTH(`PTLV_POWER_W), .DEPTH(`PTLV_STORE_DEPTH)) u_power_store (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .clr_i(store_clr),
        .wr_i(power_wr),
        .wdata_i(store_data),
        .rd_idx_i(haddr_i[3:2]),
        .count_o(power_count),
        .rd_data_o(power_rd),
        .overflow_o(power_ovf)
    );

    tlv_repeat_store #(.WIDTH(`PTLV_MINCLK_W), .DEPTH(`PTLV_STORE_DEPTH)) u_minclk_store (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .clr_i(store_clr),
        .wr_i(minclk_wr),
        .wdata_i(store_data[7:0]),
        .rd_idx_i(haddr_i[3:2]),
        .count_o(minclk_count),
        .rd_data_o(minclk_rd),
        .overflow_o(minclk_ovf)
    );

    ////////////////////////////////////////////////////////////////////////
    // Template parser
    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state <= S_IDLE;
            tmpl_rem <= 8'h00;
            obj_rem <= 8'h00;
            cur_tag <= 8'h00;
            last_tag <= 8'h00;
            seen <= 9'h000;
            val_sr <= 24'h000000;
            first_val <= 1'b0;
            char_byte <= 8'h00;
            char_valid <= 1'b0;
            store_clr <= 1'b0;
            power_wr <= 1'b0;
            minclk_wr <= 1'b0;
            store_data <= 24'h000000;
            done_o <= 1'b0;
            clk_stop_any_o <= 1'b0;
            stop_high_ok_o <= 1'b0;
            stop_low_ok_o <= 1'b0;
            stop_pref_o <= 2'h0;
            volt_class_o <= 3'h0;
        end
        else if (ce_i)
        begin
            store_clr <= 1'b0;
            power_wr <= 1'b0;
            minclk_wr <= 1'b0;
            done_o <= 1'b0;
            if (rx_valid_i)
            begin
                case (state)
                    S_IDLE:
                    begin
                        if (rx_byte_i == `PTLV_TAG_TEMPLATE)
                        begin
                            state <= S_TLEN;
                            seen <= 9'h000;
                            last_tag <= 8'h00;
                            char_valid <= 1'b0;
                            store_clr <= 1'b1;
                        end
                    end
                    S_TLEN:
                    begin
                        tmpl_rem <= rx_byte_i;
                        state <= (rx_byte_i == 8'h00) ? S_IDLE : S_TAG;
                        done_o <= (rx_byte_i == 8'h00);
                    end
                    S_TAG:
                    begin
                        tmpl_rem <= rem_after;
                        cur_tag <= rx_byte_i;
                        last_tag <= rx_byte_i;
                        if (is_defined)
                            seen[tag_idx] <= 1'b1;
                        state <= (rem_after == 8'h00) ? S_IDLE : S_LEN;
                        done_o <= (rem_after == 8'h00);
                    end
                    S_LEN:
                    begin
                        tmpl_rem <= rem_after;
                        obj_rem <= rx_byte_i;
                        first_val <= 1'b1;
                        val_sr <= 24'h000000;
                        if (rx_byte_i > rem_after)
                        begin
                            state <= S_IDLE;
                            done_o <= 1'b1;
                        end
                        else if (rx_byte_i == 8'h00)
                        begin
                            power_wr <= (cur_tag == `PTLV_TAG_POWER);
                            minclk_wr <= (cur_tag == `PTLV_TAG_MINCLK);
                            store_data <= 24'h000000;
                            state <= (rem_after == 8'h00) ? S_IDLE : S_TAG;
                            done_o <= (rem_after == 8'h00);
                        end
                        else if ((cur_tag & `PTLV_TAG_PRIVATE_MASK) == `PTLV_TAG_PRIVATE_MASK)
                            state <= S_SKIP;
                        else
                            state <= S_VAL;
                    end
                    S_VAL, S_SKIP:
                    begin
                        tmpl_rem <= rem_after;
                        obj_rem <= obj_rem - 8'h01;
                        first_val <= 1'b0;
                        val_sr <= val_next;
                        if (state == S_VAL && first_val && cur_tag == `PTLV_TAG_CHAR)
                        begin
                            char_byte <= rx_byte_i;
                            char_valid <= 1'b1;
                            clk_stop_any_o <= rx_byte_i[`PTLV_CB_STOP_ANY];
                            stop_pref_o <= rx_byte_i[`PTLV_CB_LOW:`PTLV_CB_HIGH];
                            stop_high_ok_o <= rx_byte_i[`PTLV_CB_STOP_ANY]
                                | rx_byte_i[`PTLV_CB_HIGH];
                            stop_low_ok_o <= rx_byte_i[`PTLV_CB_STOP_ANY]
                                | rx_byte_i[`PTLV_CB_LOW];
                            volt_class_o <= rx_byte_i[`PTLV_CB_CLASS_C:`PTLV_CB_CLASS_A];
                        end
                        if (obj_rem == 8'h01)
                        begin
                            power_wr <= (state == S_VAL) && (cur_tag == `PTLV_TAG_POWER);
                            minclk_wr <= (state == S_VAL) && (cur_tag == `PTLV_TAG_MINCLK);
                            store_data <= val_next;
                            state <= (rem_after == 8'h00) ? S_IDLE : S_TAG;
                            done_o <= (rem_after == 8'h00);
                        end
                    end
                    default:
                        state <= S_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags, set wins over software clear
    always @*
    begin
        next_status = status;
        next_status[`PTLV_ST_BUSY] = (state != S_IDLE);
        next_status[`PTLV_ST_DONE] = char_valid | (state == S_IDLE);
        if (ph_valid && ph_write && ph_addr == `PTLV_REG_STATUS)
            next_status = next_status & ~(hwdata_i[11:0] & `PTLV_ST_STICKY_MASK);
        if (rx_take)
        begin
            if (state == S_IDLE && rx_byte_i != `PTLV_TAG_TEMPLATE)
                next_status[`PTLV_ST_BADTPL] = 1'b1;
            if (state == S_TAG && rem_after == 8'h00)
                next_status[`PTLV_ST_OVERRUN] = 1'b1;
            if (state == S_LEN && rx_byte_i > rem_after)
                next_status[`PTLV_ST_OVERRUN] = 1'b1;
            if (state == S_TAG && is_defined && seen[tag_idx] && last_tag != rx_byte_i)
                next_status[`PTLV_ST_GROUP] = 1'b1;
            if (state == S_TAG && is_defined && last_private)
                next_status[`PTLV_ST_GROUP] = 1'b1;
            if (state == S_LEN && cur_tag == `PTLV_TAG_CHAR && rx_byte_i != `PTLV_CHAR_LEN)
                next_status[`PTLV_ST_CHARLEN] = 1'b1;
            if (state == S_TAG && rx_byte_i == `PTLV_TAG_POWER && file_kind != `PTLV_KIND_ADF)
                next_status[`PTLV_ST_POWERPOS] = 1'b1;
            if (state == S_TAG && rx_byte_i == `PTLV_TAG_ENV && file_kind != `PTLV_KIND_ROOT)
                next_status[`PTLV_ST_ENVPOS] = 1'b1;
            if (state == S_VAL && first_val && cur_tag == `PTLV_TAG_CHAR)
            begin
                if (rx_byte_i[`PTLV_CB_RSV_HI] | rx_byte_i[`PTLV_CB_RSV_LO])
                    next_status[`PTLV_ST_RSVBITS] = 1'b1;
                if (rx_byte_i[`PTLV_CB_LOW:`PTLV_CB_HIGH] == `PTLV_STOP_RSV)
                    next_status[`PTLV_ST_RSVSTOP] = 1'b1;
            end
        end
        if (done_o && file_kind == `PTLV_KIND_ROOT && !seen[0])
            next_status[`PTLV_ST_CHARMISS] = 1'b1;
        if (power_ovf | minclk_ovf)
            next_status[`PTLV_ST_STOREOVF] = 1'b1;
    end

    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            status <= 12'h000;
            error_o <= 1'b0;
        end
        else if (ce_i)
        begin
            status <= next_status;
            error_o <= |(next_status & `PTLV_ST_STICKY_MASK);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states, always OKAY
    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr <= 8'h00;
            file_kind <= `PTLV_REG_CTRL_RST;
            hrdata_o <= 32'h00000000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
        else if (ce_i)
        begin
            ph_valid <= addr_ok && (haddr_i[31:8] == 24'h000000);
            ph_write <= hwrite_i;
            ph_addr <= haddr_i[7:0];
            if (ph_valid && ph_write && ph_addr == `PTLV_REG_CTRL)
                file_kind <= hwdata_i[1:0];
            hrdata_o <= 32'h00000000;
            if (addr_ok && !hwrite_i && haddr_i[31:8] == 24'h000000)
            begin
                case (haddr_i[7:4])
                    4'h0:
                    begin
                        case (haddr_i[3:2])
                            2'h0: hrdata_o <= {30'h00000000, file_kind};
                            2'h1: hrdata_o <= {20'h00000, status};
                            2'h2: hrdata_o <= {23'h000000, char_valid, char_byte};
                            default: hrdata_o <= {25'h0000000, minclk_count, 1'b0, power_count};
                        endcase
                    end
                    4'h1: hrdata_o <= {8'h00, power_rd};
                    4'h2: hrdata_o <= {24'h000000, minclk_rd};
                    default: hrdata_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // ptlv_decoder
`default_nettype wire

/* inc/ptlv_defs.vh */
// Constants for the proprietary template decoder
`ifndef PTLV_DEFS_VH
`define PTLV_DEFS_VH

// Tags
`define PTLV_TAG_TEMPLATE 8'ha5
`define PTLV_TAG_CHAR 8'h80
`define PTLV_TAG_POWER 8'h81
`define PTLV_TAG_MINCLK 8'h82
`define PTLV_TAG_MEMORY 8'h83
`define PTLV_TAG_DETAILS 8'h84
`define PTLV_TAG_RESERVED 8'h85
`define PTLV_TAG_MAXSIZE 8'h86
`define PTLV_TAG_COMMANDS 8'h87
`define PTLV_TAG_ENV 8'h88
`define PTLV_TAG_PRIVATE_MASK 8'hc0
`define PTLV_CHAR_LEN 8'h01

// File kinds
`define PTLV_KIND_ROOT 2'h0
`define PTLV_KIND_ADF 2'h1
`define PTLV_KIND_DIR 2'h2
`define PTLV_KIND_ELEM 2'h3

// Characteristics byte fields
`define PTLV_CB_STOP_ANY 0
`define PTLV_CB_RSV_LO 1
`define PTLV_CB_HIGH 2
`define PTLV_CB_LOW 3
`define PTLV_CB_CLASS_A 4
`define PTLV_CB_CLASS_C 6
`define PTLV_CB_RSV_HI 7
`define PTLV_STOP_RSV 2'h3

// Register offsets
`define PTLV_REG_CTRL 8'h00
`define PTLV_REG_STATUS 8'h04
`define PTLV_REG_CHAR 8'h08
`define PTLV_REG_COUNT 8'h0c
`define PTLV_REG_POWER 8'h10
`define PTLV_REG_MINCLK 8'h20
`define PTLV_REG_CTRL_RST 2'h0

// Status bits
`define PTLV_ST_DONE 0
`define PTLV_ST_BUSY 1
`define PTLV_ST_BADTPL 2
`define PTLV_ST_OVERRUN 3
`define PTLV_ST_GROUP 4
`define PTLV_ST_CHARLEN 5
`define PTLV_ST_CHARMISS 6
`define PTLV_ST_POWERPOS 7
`define PTLV_ST_ENVPOS 8
`define PTLV_ST_RSVBITS 9
`define PTLV_ST_RSVSTOP 10
`define PTLV_ST_STOREOVF 11
`define PTLV_ST_STICKY_MASK 12'hffc

// Repeat store
`define PTLV_STORE_DEPTH 4
`define PTLV_POWER_W 24
`define PTLV_MINCLK_W 8

`endif

/* core/tlv_repeat_store.v */
// Ordered store for repeated nested objects
`timescale 1ns/100ps
`default_nettype none
module tlv_repeat_store #(
    parameter WIDTH = 8,
    parameter DEPTH = 4
) (
    input wire clk_i,
    input wire srst_i,
    input wire ce_i,
    input wire clr_i,
    input wire wr_i,
    input wire [WIDTH-1:0] wdata_i,
    input wire [1:0] rd_idx_i,
    output wire [2:0] count_o,
    output wire [WIDTH-1:0] rd_data_o,
    output wire overflow_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [2:0] count;
    reg overflow;
    integer i;

    ////////////////////////////////////////////////////////////////////////
    // Entries kept in arrival order
    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            count <= 3'h0;
            overflow <= 1'b0;
            for (i = 0; i < DEPTH; i = i + 1)
                mem[i] <= {WIDTH{1'b0}};
        end
        else if (ce_i)
        begin
            if (clr_i)
            begin
                count <= 3'h0;
                overflow <= 1'b0;
            end
            else if (wr_i)
            begin
                if (count < DEPTH)
                begin
                    mem[count[1:0]] <= wdata_i;
                    count <= count + 3'h1;
                end
                else
                    overflow <= 1'b1;
            end
        end
    end

    assign count_o = count;
    assign rd_data_o = mem[rd_idx_i];
    assign overflow_o = overflow;
endmodule // tlv_repeat_store
`default_nettype wire

/* dv/ptlv_decoder_monitor.sv */
// Concurrent checks on the template decoder ports
`timescale 1ns/100ps
`default_nettype none
module ptlv_decoder_monitor (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic rx_valid_i,
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic done_o,
    input wire logic error_o,
    input wire logic clk_stop_any_o,
    input wire logic stop_high_ok_o,
    input wire logic stop_low_ok_o,
    input wire logic [1:0] stop_pref_o,
    input wire logic [2:0] volt_class_o
);
    default clocking mon_clk @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    ////////////////////////////////////////////////////////////////////////
    a_bus_ready_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus slave not ready or not okay");
    a_rd_data_idle: assert property
        (!$past(hsel_i && htrans_i[1] && hready_i && !hwrite_i) |-> hrdata_o == 32'h0)
        else $error("read data not cleared outside a read");
    a_stop_high_ok: assert property (
        stop_high_ok_o == (clk_stop_any_o | stop_pref_o[0]))
        else $error("high stop permission wrong");
    a_stop_low_ok: assert property (
        stop_low_ok_o == (clk_stop_any_o | stop_pref_o[1]))
        else $error("low stop permission wrong");
    a_never_stop: assert property (
        (!clk_stop_any_o && stop_pref_o == 2'h0) |-> !(stop_high_ok_o || stop_low_ok_o))
        else $error("stop allowed with all bits clear");
    a_any_level: assert property (
        clk_stop_any_o |-> (stop_high_ok_o && stop_low_ok_o))
        else $error("free stop without both levels");
    a_done_pulse: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    a_done_cause: assert property ($rose(done_o) |-> $past(rx_valid_i))
        else $error("done without a byte");
    a_class_cause: assert property ($changed(volt_class_o) |-> $past(rx_valid_i))
        else $error("voltage classes changed without a byte");
    a_rsv_stop_err: assert property (
        $rose(stop_pref_o == 2'h3) |-> ##[1:2] error_o)
        else $error("reserved stop code not flagged");

    ////////////////////////////////////////////////////////////////////////
    c_free_stop: cover property (done_o && clk_stop_any_o);
    c_rsv_stop: cover property (stop_pref_o == 2'h3);
    c_bus_read: cover property (hsel_i && htrans_i[1] && !hwrite_i);
endmodule // ptlv_decoder_monitor

bind ptlv_decoder ptlv_decoder_monitor mon (
    .clk_i, .srst_i, .rx_valid_i, .hsel_i, .htrans_i, .hwrite_i, .hready_i,
    .hrdata_o, .hreadyout_o, .hresp_o, .done_o, .error_o, .clk_stop_any_o,
    .stop_high_ok_o, .stop_low_ok_o, .stop_pref_o, .volt_class_o
);
`default_nettype wire

/* dv/card_byte_source.sv */
// Card side model sending template byte streams
`timescale 1ns/100ps
`default_nettype none
module card_byte_source (
    input wire logic clk_i,
    output logic rx_valid_o,
    output logic [7:0] rx_byte_o
);
    typedef logic [7:0] bytes_t[$];

    initial
    begin
        rx_valid_o = 1'b0;
        rx_byte_o = 8'h00;
    end

    // Whole template, one byte per cycle, then the line is released
    task automatic send(input bytes_t q);
        foreach (q[i])
        begin
            rx_valid_o <= 1'b1;
            rx_byte_o <= q[i];
            @(posedge clk_i);
        end
        rx_valid_o <= 1'b0;
        rx_byte_o <= ~rx_byte_o;
    endtask
endmodule // card_byte_source
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the template decoder
`timescale 1ns/100ps
`default_nettype none
`include "ptlv_defs.vh"
module testbench;
    typedef logic [7:0] bytes_t[$];
    logic clk_i, srst_i, hsel_i, hwrite_i, rx_valid, hreadyout_o, hresp_o, done_o, error_o;
    logic any_o, hi_o, lo_o, ce_i;
    logic [1:0] htrans_i, pref_o;
    logic [2:0] cls_o;
    logic [7:0] rx_byte, cb;
    logic [23:0] p, q;
    logic [15:0] c;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
    int fail_count, samples_checked, cycles, dones;
    integer seed;

    card_byte_source src (.clk_i(clk_i), .rx_valid_o(rx_valid), .rx_byte_o(rx_byte));
    ptlv_decoder dut (
        .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .rx_valid_i(rx_valid),
        .rx_byte_i(rx_byte), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
        .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
        .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .done_o(done_o),
        .error_o(error_o), .clk_stop_any_o(any_o), .stop_high_ok_o(hi_o),
        .stop_low_ok_o(lo_o), .stop_pref_o(pref_o), .volt_class_o(cls_o)
    );

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i)
    begin
        cycles++;
        if (done_o === 1'b1)
            dones++;
        if (cycles == 20000)
        begin
            fail_count++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] exp_char(input logic [7:0] v);
        return {v[6:4], v[3:2], v[0] | v[2], v[0] | v[3], v[0]};
    endfunction

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // One single AHB transfer, entered just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr_i <= {24'h0, a};
        hwrite_i <= w;
        htrans_i <= 2'h2;
        hsel_i <= 1'b1;
        @(posedge clk_i);
        while (hreadyout_o !== 1'b1) @(posedge clk_i);
        htrans_i <= 2'h0;
        hsel_i <= 1'b0;
        hwdata_i <= d;
        @(posedge clk_i);
        while (hreadyout_o !== 1'b1) @(posedge clk_i);
        rd = hrdata_o;
    endtask

    // Send a template, compare sticky status under a mask, then clear it
    task automatic tcase(input bytes_t b, input logic [31:0] exp, input logic [31:0] m);
        int d0;
        d0 = dones;
        src.send(b);
        for (int k = 0; k < 4 && dones == d0; k++) @(posedge clk_i);
        bus(1'b0, `PTLV_REG_STATUS, 32'h0);
        chk("status", rd & m, exp);
        chk("error", {31'h0, error_o}, {31'h0, |exp});
        bus(1'b1, `PTLV_REG_STATUS, 32'hffc);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        seed = 32'h63f47d13;
        srst_i = 1'b1;
        ce_i = 1'b1;
        hsel_i = 1'b0;
        hwrite_i = 1'b0;
        htrans_i = 2'h0;
        haddr_i = 32'h0;
        hwdata_i = 32'h0;
        repeat (3) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        chk("reset outs", {hreadyout_o, hresp_o, done_o, error_o, any_o, hi_o, lo_o, pref_o,
            cls_o}, 32'h800);
        bus(1'b0, `PTLV_REG_CTRL, 32'h0);
        chk("kind reset", rd, 32'h0);
        bus(1'b1, `PTLV_REG_CTRL, 32'h3);
        bus(1'b0, `PTLV_REG_CTRL, 32'h0);
        chk("kind", rd, 32'h3);
        bus(1'b1, 8'h30, 32'hffffffff);
        bus(1'b0, 8'h30, 32'h0);
        chk("unmapped", rd, 32'h0);
        ce_i <= 1'b0;
        src.send('{8'h5a});
        ce_i <= 1'b1;
        bus(1'b0, `PTLV_REG_STATUS, 32'h0);
        chk("frozen", rd & 32'hffc, 32'h0);
        // Root file: characteristics bytes, corner values then random
        bus(1'b1, `PTLV_REG_CTRL, 32'h0);
        for (int i = 0; i < 10; i++)
        begin
            cb = 8'($random(seed));
            cb[7] = 1'b0;
            cb[1] = 1'b0;
            if (cb[3:2] == 2'h3)
                cb[3] = 1'b0;
            if (i < 2)
                cb = {7'h0, i[0]};
            tcase('{8'ha5, 8'h03, 8'h80, 8'h01, cb}, 32'h0, 32'hffc);
            chk("char outs", {24'h0, cls_o, pref_o, hi_o, lo_o, any_o}, {24'h0, exp_char(cb)});
            bus(1'b0, `PTLV_REG_CHAR, 32'h0);
            chk("char reg", rd, {23'h0, 1'b1, cb});
        end
        tcase('{8'ha5, 8'h03, 8'h80, 8'h01, 8'h0d}, 32'h400, 32'hffc);
        tcase('{8'ha5, 8'h03, 8'h80, 8'h01, 8'h83}, 32'h200, 32'hffc);
        tcase('{8'ha5, 8'h04, 8'h80, 8'h02, 8'h01, 8'h00}, 32'h020, 32'h020);
        tcase('{8'ha5, 8'h02, 8'h83, 8'h00}, 32'h040, 32'hffc);
        tcase('{8'ha5, 8'h05, 8'h81, 8'h03, 8'h11, 8'h22, 8'h33}, 32'h0c0, 32'hffc);
        tcase('{8'h5a}, 32'h004, 32'hffc);
        tcase('{8'ha5, 8'h03, 8'h80, 8'h05}, 32'h008, 32'h008);
        tcase('{8'ha5, 8'h05, 8'h80, 8'h01, 8'h01, 8'hc3, 8'h00}, 32'h0, 32'hffc);
        tcase('{8'ha5, 8'h06, 8'h80, 8'h01, 8'h01, 8'h88, 8'h01, 8'h00}, 32'h0, 32'hffc);
        bus(1'b1, `PTLV_REG_CTRL, 32'h2);
        tcase('{8'ha5, 8'h03, 8'h88, 8'h01, 8'h00}, 32'h100, 32'hffc);
        bus(1'b1, `PTLV_REG_CTRL, 32'h3);
        tcase('{8'ha5, 8'h05, 8'h81, 8'h03, 8'h01, 8'h02, 8'h03}, 32'h080, 32'hffc);
        // Application directory: tags 81 to 87, grouping and repeats
        bus(1'b1, `PTLV_REG_CTRL, 32'h1);
        tcase('{8'ha5, 8'h0a, 8'h83, 8'h00, 8'h84, 8'h00, 8'h85, 8'h00, 8'h86, 8'h00, 8'h87,
            8'h00}, 32'h0, 32'hffc);
        tcase('{8'ha5, 8'h08, 8'h82, 8'h01, 8'h10, 8'h83, 8'h00, 8'h82, 8'h01, 8'h20}, 32'h010,
            32'hffc);
        p = 24'($random(seed));
        q = 24'($random(seed));
        c = 16'($random(seed));
        tcase('{8'ha5, 8'h13, 8'h81, 8'h03, p[23:16], p[15:8], p[7:0], 8'h81, 8'h03, q[23:16],
            q[15:8], q[7:0], 8'h82, 8'h01, c[7:0], 8'h82, 8'h01, c[15:8], 8'hc1, 8'h01, 8'h55},
            32'h0, 32'hffc);
        bus(1'b0, `PTLV_REG_COUNT, 32'h0);
        chk("counts", rd, 32'h22);
        bus(1'b0, `PTLV_REG_POWER, 32'h0);
        chk("power0", rd, {8'h0, p});
        bus(1'b0, 8'h14, 32'h0);
        chk("power1", rd, {8'h0, q});
        bus(1'b0, `PTLV_REG_MINCLK, 32'h0);
        chk("clock0", rd, {24'h0, c[7:0]});
        bus(1'b0, 8'h24, 32'h0);
        chk("clock1", rd, {24'h0, c[15:8]});
        tcase('{8'ha5, 8'h11, 8'h82, 8'h01, 8'h01, 8'h82, 8'h01, 8'h02, 8'h82, 8'h01, 8'h03,
            8'h82, 8'h01, 8'h04, 8'h82, 8'h01, 8'h05, 8'hc1, 8'h00}, 32'h800, 32'h800);
        end_sim();
    end
endmodule // testbench
`default_nettype wire
